// *** hw/lmrs_pkg.sv ***
// package: constants, field carrier and gf helpers for the long message rs encoder
package lmrs_pkg;

  // ---------------------------------------------------------------
  // code shape
  // ---------------------------------------------------------------
  localparam int INFO_BYTES   = 34;
  localparam int PARITY_BYTES = 14;
  localparam int CODE_BYTES   = INFO_BYTES + PARITY_BYTES;
  localparam int PAYLOAD_BITS = INFO_BYTES * 8;
  localparam int CNT_W        = 6;
  localparam logic [CNT_W-1:0] LAST_INFO_IDX   = 6'h21;
  localparam logic [CNT_W-1:0] LAST_PARITY_IDX = 6'h0d;
  localparam logic [CNT_W-1:0] LAST_CODE_IDX   = 6'h2f;

  // field polynomial x^8+x^7+x^2+x+1 with the x^8 term dropped
  localparam logic [7:0] PRIM_POLY = 8'h87;

  // generator exponents, index j is the coefficient of x^j (x^14 is monic)
  localparam int GEN_EXP [PARITY_BYTES] =
    '{241, 70, 39, 13, 64, 22, 138, 135, 140, 26, 70, 21, 49, 82};

  // ---------------------------------------------------------------
  // payload constants
  // ---------------------------------------------------------------
  localparam logic [4:0] PAYLOAD_TYPE_LONG = 5'h01;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFS   = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
  localparam logic [APB_AW-1:0] COUNT_OFS  = 12'h008;
  localparam int CTRL_EN_BIT     = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_IDX_LSB  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ---------------------------------------------------------------
  // field carrier from the message source
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  addrQualifier;
    logic [23:0] aircraftAddress;
    logic [22:0] latitude;
    logic [23:0] longitude;
    logic        altitudeType;
    logic [11:0] altitude;
    logic [3:0]  integrity_category;
    logic [1:0]  airGround;
    logic [10:0] northVelocity;
    logic [10:0] eastVelocity;
    logic [10:0] verticalVelocity;
    logic        timeCoupled;
    logic [15:0] callWord1;
    logic [15:0] callWord2;
    logic [15:0] callWord3;
    logic [2:0]  emergency;
    logic [2:0]  formatVersion;
    logic [1:0]  source_integrity_level;
    logic [11:0] message_start_offset;
    logic [3:0]  position_accuracy;
    logic [2:0]  velocity_accuracy;
    logic        baro_integrity;
    logic [1:0]  capability_class_codes;
    logic [2:0]  operational_mode_codes;
    logic        trueMagnitude;
    logic [11:0] secondaryAltitude;
  } lmrs_fields_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PARITY} lmrs_state_t;

  // ---------------------------------------------------------------
  // gf(256) arithmetic
  // ---------------------------------------------------------------
  function automatic logic [7:0] gfMulAlpha(input logic [7:0] a);
    gfMulAlpha = {a[6:0], 1'b0} ^ (a[7] ? PRIM_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh  = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        acc = acc ^ sh;
      sh = gfMulAlpha(sh);
    end
    gfMul = acc;
  endfunction

  function automatic logic [7:0] gfPow(input int e);
    logic [7:0] x;
    x = 8'h01;
    for (int i = 0; i < 255; i++)
    begin
      if (i < e)
        x = gfMulAlpha(x);
    end
    gfPow = x;
  endfunction

endpackage

// *** hw/lmrs_rs_lfsr.sv ***
// module: rs(48,34) parity remainder register with shift-out
`timescale 1ns/1ps
`default_nettype none
module lmrs_rs_lfsr (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clear,
  input  wire logic       feed,
  input  wire logic       drain,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] parityOut
);

  logic [7:0] rem_r   [lmrs_pkg::PARITY_BYTES];
  logic [7:0] rem_nxt [lmrs_pkg::PARITY_BYTES];
  logic [7:0] fb;

  // ---------------------------------------------------------------
  // division by g(x), remainder high symbol leaves first
  // ---------------------------------------------------------------
  always_comb
  begin
    fb = dataIn ^ rem_r[lmrs_pkg::PARITY_BYTES-1];
    for (int j = 0; j < lmrs_pkg::PARITY_BYTES; j++)
      rem_nxt[j] = rem_r[j];
    if (clear)
    begin
      for (int j = 0; j < lmrs_pkg::PARITY_BYTES; j++)
        rem_nxt[j] = 8'h00;
    end
    else if (feed)
    begin
      rem_nxt[0] = lmrs_pkg::gfMul(fb, lmrs_pkg::gfPow(lmrs_pkg::GEN_EXP[0]));
      for (int j = 1; j < lmrs_pkg::PARITY_BYTES; j++)
        rem_nxt[j] = rem_r[j-1] ^ lmrs_pkg::gfMul(fb, lmrs_pkg::gfPow(lmrs_pkg::GEN_EXP[j]));
    end
    else if (drain)
    begin
      rem_nxt[0] = 8'h00;
      for (int j = 1; j < lmrs_pkg::PARITY_BYTES; j++)
        rem_nxt[j] = rem_r[j-1];
    end
  end

  // remainder registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int j = 0; j < lmrs_pkg::PARITY_BYTES; j++)
        rem_r[j] <= 8'h00;
    end
    else
    begin
      for (int j = 0; j < lmrs_pkg::PARITY_BYTES; j++)
        rem_r[j] <= rem_nxt[j];
    end
  end

  assign parityOut = rem_r[lmrs_pkg::PARITY_BYTES-1];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  clear_empties_a: assert property (clear |=> (rem_r[0] == 8'h00 && parityOut == 8'h00))
    else $error("remainder not empty after clear");
  drain_order_a: assert property ((drain && !clear && !feed) |=>
      parityOut == $past(rem_r[lmrs_pkg::PARITY_BYTES-2]))
    else $error("parity symbols leave out of order");
  // first symbol into an emptied divider: top stage is zero exactly when the symbol is zero
  first_symbol_a: assert property ((feed && !clear && $past(clear)) |=>
      ((parityOut == 8'h00) == ($past(dataIn) == 8'h00)))
    else $error("first symbol left the remainder wrong");

endmodule
`default_nettype wire

// *** hw/lmrs_encoder.sv ***
// module: long message payload packer and rs(48,34) encoder with apb control
//
// Contract
// - generator is monic degree 14 with the listed alpha exponents
// - exactly 34 information bytes per message, leftmost is most significant
// - 14 parity symbols are the remainder of shifted message by generator
// - systematic: information bytes pass unchanged, parity follows them
// - emit all 48 symbols, information then parity, leftmost first
// - bits grouped into bytes, leftmost byte and msb first
// - payload opens with type code one, address qualifier, aircraft address
// - then position, altitude, integrity, velocities, time flag, reserved
// - then three 16-bit emitter category and call-sign words
// - then emergency, version, integrity level, six offset bits, reserved
// - then accuracies, baro integrity, class, mode, magnitude, 18 zeros
// - ends with secondary altitude and 28 zero bits, 34 bytes total
// - field arithmetic over gf(256) with x^8+x^7+x^2+x+1
// - generator roots are alpha^120 through alpha^133
// - first parity symbol out is most significant, right after data
`timescale 1ns/1ps
`default_nettype none
module lmrs_encoder (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        msgStart,
  input  wire lmrs_pkg::lmrs_fields_t      msgFields,
  output logic                             busy_r,
  output logic                             outValid_r,
  output logic                             outLast_r,
  output logic [7:0]                       outByte_r,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [lmrs_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr
);

  // ---------------------------------------------------------------
  // payload assembly
  // ---------------------------------------------------------------
  function automatic logic [lmrs_pkg::PAYLOAD_BITS-1:0] packPayload(
    input lmrs_pkg::lmrs_fields_t f);
    packPayload = {
      lmrs_pkg::PAYLOAD_TYPE_LONG, f.addrQualifier, f.aircraftAddress,
      f.latitude, f.longitude, f.altitudeType, f.altitude,
      f.integrity_category, f.airGround, 1'b0,
      f.northVelocity, f.eastVelocity, f.verticalVelocity, f.timeCoupled, 3'h0,
      f.callWord1, f.callWord2, f.callWord3,
      f.emergency, f.formatVersion, f.source_integrity_level,
      f.message_start_offset[5:0], 2'h0,
      f.position_accuracy, f.velocity_accuracy, f.baro_integrity,
      f.capability_class_codes, f.operational_mode_codes, f.trueMagnitude, 18'h0,
      f.secondaryAltitude, 28'h0
    };
  endfunction

  // ---------------------------------------------------------------
  // encoder sequencing state
  // ---------------------------------------------------------------
  lmrs_pkg::lmrs_state_t state_r, state_nxt;
  logic [lmrs_pkg::PAYLOAD_BITS-1:0] payload_r, payload_nxt;
  logic [lmrs_pkg::CNT_W-1:0] idx_r, idx_nxt;
  logic       busy_nxt, outValid_nxt, outLast_nxt;
  logic [7:0] outByte_nxt;
  logic [15:0] msgCount_r, msgCount_nxt;
  logic       enable_r, enable_nxt;
  logic       lfsrClear, lfsrFeed, lfsrDrain;
  logic [7:0] parityByte;
  logic       accept;

  assign accept = msgStart && enable_r && (state_r == lmrs_pkg::ST_IDLE);

  // next-state: load, 34 data bytes, 14 parity bytes
  always_comb
  begin
    state_nxt    = state_r;
    payload_nxt  = payload_r;
    idx_nxt      = idx_r;
    busy_nxt     = busy_r;
    outValid_nxt = 1'b0;
    outLast_nxt  = 1'b0;
    outByte_nxt  = outByte_r;
    msgCount_nxt = msgCount_r;
    lfsrClear    = 1'b0;
    lfsrFeed     = 1'b0;
    lfsrDrain    = 1'b0;
    case (state_r)
      lmrs_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          payload_nxt = packPayload(msgFields);
          idx_nxt     = '0;
          busy_nxt    = 1'b1;
          lfsrClear   = 1'b1;
          state_nxt   = lmrs_pkg::ST_DATA;
        end
      end
      lmrs_pkg::ST_DATA:
      begin
        // top byte leaves unchanged and feeds the divider
        outByte_nxt  = payload_r[lmrs_pkg::PAYLOAD_BITS-1 -: 8];
        outValid_nxt = 1'b1;
        lfsrFeed     = 1'b1;
        payload_nxt  = {payload_r[lmrs_pkg::PAYLOAD_BITS-9:0], 8'h00};
        if (idx_r == lmrs_pkg::LAST_INFO_IDX)
        begin
          idx_nxt   = '0;
          state_nxt = lmrs_pkg::ST_PARITY;
        end
        else
          idx_nxt = idx_r + 6'h01;
      end
      lmrs_pkg::ST_PARITY:
      begin
        outByte_nxt  = parityByte;
        outValid_nxt = 1'b1;
        lfsrDrain    = 1'b1;
        if (idx_r == lmrs_pkg::LAST_PARITY_IDX)
        begin
          outLast_nxt  = 1'b1;
          busy_nxt     = 1'b0;
          msgCount_nxt = msgCount_r + 16'h0001;
          idx_nxt      = '0;
          state_nxt    = lmrs_pkg::ST_IDLE;
        end
        else
          idx_nxt = idx_r + 6'h01;
      end
      default:
      begin
        state_nxt = lmrs_pkg::ST_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // encoder registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r    <= lmrs_pkg::ST_IDLE;
      payload_r  <= '0;
      idx_r      <= '0;
      busy_r     <= 1'b0;
      outValid_r <= 1'b0;
      outLast_r  <= 1'b0;
      outByte_r  <= 8'h00;
      msgCount_r <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      payload_r  <= payload_nxt;
      idx_r      <= idx_nxt;
      busy_r     <= busy_nxt;
      outValid_r <= outValid_nxt;
      outLast_r  <= outLast_nxt;
      outByte_r  <= outByte_nxt;
      msgCount_r <= msgCount_nxt;
    end
  end

  // parity divider over gf(256), roots alpha^120..alpha^133
  lmrs_rs_lfsr u_lfsr (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clear     (lfsrClear),
    .feed      (lfsrFeed),
    .drain     (lfsrDrain),
    .dataIn    (payload_r[lmrs_pkg::PAYLOAD_BITS-1 -: 8]),
    .parityOut (parityByte)
  );

  // ---------------------------------------------------------------
  // apb slave: zero-wait, answer in the access cycle
  // ---------------------------------------------------------------
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt;
  logic        known;

  always_comb
  begin
    known = (paddr == lmrs_pkg::CTRL_OFS) || (paddr == lmrs_pkg::STATUS_OFS)
            || (paddr == lmrs_pkg::COUNT_OFS);
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    enable_nxt  = enable_r;
    if (psel && !penable)
    begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !known;
      if (paddr == lmrs_pkg::CTRL_OFS)
        prdata_nxt[lmrs_pkg::CTRL_EN_BIT] = enable_r;
      else if (paddr == lmrs_pkg::STATUS_OFS)
      begin
        prdata_nxt[lmrs_pkg::STATUS_BUSY_BIT] = busy_r;
        prdata_nxt[lmrs_pkg::STATUS_IDX_LSB +: lmrs_pkg::CNT_W] = idx_r;
      end
      else if (paddr == lmrs_pkg::COUNT_OFS)
        prdata_nxt[15:0] = msgCount_r;
    end
    // write lands at the completing edge
    if (psel && penable && pready && pwrite && paddr == lmrs_pkg::CTRL_OFS)
      enable_nxt = pwdata[lmrs_pkg::CTRL_EN_BIT];
  end

  // bus registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      enable_r <= lmrs_pkg::CTRL_RESET[lmrs_pkg::CTRL_EN_BIT];
    end
    else
    begin
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
      enable_r <= enable_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [lmrs_pkg::CNT_W-1:0] outCnt_r;

  // count of symbols emitted in the current codeword
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      outCnt_r <= '0;
    else if (outLast_r)
      outCnt_r <= '0;
    else if (outValid_r)
      outCnt_r <= outCnt_r + 6'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence seqAccept;
    accept;
  endsequence
  sequence seqFirstByte;
    ##2 (outValid_r && outByte_r[7:3] == lmrs_pkg::PAYLOAD_TYPE_LONG);
  endsequence

  start_busy_a: assert property (seqAccept |=> busy_r)
    else $error("busy not raised after start");
  type_first_a: assert property (seqAccept |-> seqFirstByte)
    else $error("first byte lacks the long type code");
  last_count_a: assert property (outLast_r |-> (outValid_r && outCnt_r == lmrs_pkg::LAST_CODE_IDX))
    else $error("codeword length is not 48");
  busy_release_a: assert property (outLast_r |-> !busy_r)
    else $error("busy held past the last parity byte");
  data_pass_a: assert property ((state_r == lmrs_pkg::ST_DATA) |=>
      outByte_r == $past(payload_r[lmrs_pkg::PAYLOAD_BITS-1 -: 8]))
    else $error("information byte altered");
  parity_after_a: assert property ($rose(state_r == lmrs_pkg::ST_PARITY) |->
      outCnt_r == lmrs_pkg::LAST_INFO_IDX)
    else $error("parity began after the wrong byte count");
  gap_free_a: assert property ($rose(busy_r) |-> ##1 outValid_r [*8])
    else $error("codeword stream has a gap");
  apb_answer_a: assert property ((psel && !penable) |=> pready)
    else $error("apb access not answered");

endmodule
`default_nettype wire

// *** verif/lmrs_frame_sink.sv ***
// partner model: transmitter framing side that collects the codeword stream
`timescale 1ns/1ps
`default_nettype none
module lmrs_frame_sink (
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  input  wire logic                                outValid,
  input  wire logic                                outLast,
  input  wire logic [7:0]                          outByte,
  output logic      [lmrs_pkg::CODE_BYTES*8-1:0]   rxFrame_r,
  output logic      [6:0]                          rxLen_r,
  output logic      [6:0]                          lastLen_r,
  output logic      [7:0]                          frameCnt_r
);
  logic [lmrs_pkg::CODE_BYTES*8-1:0] rxFrame_nxt;
  logic [6:0]                        rxLen_nxt;
  logic [6:0]                        lastLen_nxt;
  logic [7:0]                        frameCnt_nxt;

  // take each strobed byte, first byte ends up in the top of the frame
  always_comb
  begin
    rxFrame_nxt  = rxFrame_r;
    rxLen_nxt    = rxLen_r;
    lastLen_nxt  = lastLen_r;
    frameCnt_nxt = frameCnt_r;
    if (outValid)
    begin
      rxFrame_nxt = {rxFrame_r[lmrs_pkg::CODE_BYTES*8-9:0], outByte};
      rxLen_nxt   = rxLen_r + 7'h01;
      if (outLast)
      begin
        lastLen_nxt  = rxLen_r + 7'h01;
        rxLen_nxt    = 7'h00;
        frameCnt_nxt = frameCnt_r + 8'h01;
      end
    end
  end

  // register the capture state
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxFrame_r  <= '0;
      rxLen_r    <= 7'h00;
      lastLen_r  <= 7'h00;
      frameCnt_r <= 8'h00;
    end
    else
    begin
      rxFrame_r  <= rxFrame_nxt;
      rxLen_r    <= rxLen_nxt;
      lastLen_r  <= lastLen_nxt;
      frameCnt_r <= frameCnt_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: codeword content, stream timing and apb register checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CW = lmrs_pkg::CODE_BYTES * 8;
  localparam logic [CW-1:0] GOLD = {96'h08faa123555555c000000354, 96'h064432c0280e1b4d090cfc04,
                                    96'h887400000003500000000e19, 96'h85ff9c6b33066ca9f43d12e8};
  logic                        core_clk;
  logic                        rst_b;
  logic                        msgStart;
  lmrs_pkg::lmrs_fields_t      msgFields;
  logic                        busy, outValid, outLast, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                  outByte;
  logic [lmrs_pkg::APB_AW-1:0] paddr;
  logic [31:0]                 pwdata, prdata;
  logic [CW-1:0]               rxFrame;
  logic [6:0]                  rxLen, lastLen;
  logic [7:0]                  frameCnt;
  int                          errors, testsRun;

  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;

  lmrs_encoder u_dut (.core_clk(core_clk), .rst_b(rst_b), .msgStart(msgStart),
    .msgFields(msgFields), .busy_r(busy), .outValid_r(outValid), .outLast_r(outLast),
    .outByte_r(outByte), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lmrs_frame_sink u_sink (.core_clk(core_clk), .rst_b(rst_b), .outValid(outValid),
    .outLast(outLast), .outByte(outByte), .rxFrame_r(rxFrame), .rxLen_r(rxLen),
    .lastLen_r(lastLen), .frameCnt_r(frameCnt));

  // ---------------------------------------------------------------
  // reporting and reference model
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [CW-1:0] exp, input logic [CW-1:0] got);
    testsRun++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    errors++;
    $display("BAD %s expected done got timeout", what);
    give_verdict();
  endtask

  // gf(256) product, reduced by x^8+x^7+x^2+x+1
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      p = {p[6:0], 1'b0} ^ (p[7] ? 8'h87 : 8'h00);
      if (b[i])
        p = p ^ a;
    end
    return p;
  endfunction

  // packs the payload, builds the generator from its roots, divides
  function automatic logic [CW-1:0] ref_code(input lmrs_pkg::lmrs_fields_t f);
    logic [271:0] pl;
    logic [7:0]   g [15];
    logic [7:0]   r [14];
    logic [7:0]   rt;
    logic [7:0]   fb;
    pl = {5'h01, f.addrQualifier, f.aircraftAddress, f.latitude, f.longitude, f.altitudeType,
          f.altitude, f.integrity_category, f.airGround, 1'b0, f.northVelocity, f.eastVelocity,
          f.verticalVelocity, f.timeCoupled, 3'h0, f.callWord1, f.callWord2, f.callWord3,
          f.emergency, f.formatVersion, f.source_integrity_level, f.message_start_offset[5:0],
          2'h0, f.position_accuracy, f.velocity_accuracy, f.baro_integrity,
          f.capability_class_codes, f.operational_mode_codes, f.trueMagnitude, 18'h0,
          f.secondaryAltitude, 28'h0};
    g = '{default: 8'h00};
    r = '{default: 8'h00};
    g[0] = 8'h01;
    rt = 8'h01;
    for (int i = 0; i < 134; i++)
    begin
      if (i >= 120)
      begin
        for (int k = 14; k > 0; k--)
          g[k] = g[k-1] ^ gm(g[k], rt);
        g[0] = gm(g[0], rt);
      end
      rt = gm(rt, 8'h02);
    end
    for (int n = 0; n < 34; n++)
    begin
      fb = pl[271-8*n -: 8] ^ r[13];
      for (int k = 13; k > 0; k--)
        r[k] = r[k-1] ^ gm(fb, g[k]);
      r[0] = gm(fb, g[0]);
    end
    ref_code = {pl, 112'h0};
    for (int k = 0; k < 14; k++)
      ref_code[8*k +: 8] = r[k];
  endfunction

  // ---------------------------------------------------------------
  // drivers and scenarios
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // ready, read data and error are taken as they stand at the completing edge
    for (int i = 0; i < 20; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
      if (i == 19)
        give_up("apb ready");
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic expErr,
                        input string what);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, {expErr, exp}, {err, rd});
  endtask

  task automatic start_msg(input lmrs_pkg::lmrs_fields_t f);
    @(posedge core_clk);
    msgStart  <= 1'b1;
    msgFields <= f;
    @(posedge core_clk);
    msgStart <= 1'b0;
    #1;
  endtask

  // mode 1 chains the next start into the last cycle, mode 2 pokes a start mid-frame
  task automatic watch_frame(input logic [CW-1:0] exp, input int mode,
                             input lmrs_pkg::lmrs_fields_t fNext);
    int n;
    chk("busy after start", 1'b1, busy);
    chk("valid before first byte", 1'b0, outValid);
    @(posedge core_clk);
    #1;
    chk("first byte", {1'b1, exp[CW-1 -: 8]}, {outValid, outByte});
    n = 1;
    while (outLast !== 1'b1)
    begin
      if (n > 60)
        give_up("frame end");
      @(posedge core_clk);
      if (mode == 1 && n == 47)
        msgFields <= fNext;
      if (mode != 0)
        msgStart <= (mode == 1) ? (n == 47) : (n == 20);
      #1;
      chk("valid in frame", 1'b1, outValid);
      n++;
    end
    chk("last byte index", 47, n - 1);
    chk("busy at last byte", 1'b0, busy);
    @(posedge core_clk);
    msgStart <= 1'b0;
    #1;
    chk("codeword", exp, rxFrame);
    chk("frame length", 48, lastLen);
    if (mode != 1)
      chk("idle after frame", 2'b00, {busy, outValid});
  endtask

  initial
  begin
    lmrs_pkg::lmrs_fields_t gold;
    lmrs_pkg::lmrs_fields_t pat;
    logic [255:0]           bits;
    logic [31:0]            rd;
    logic                   err;
    core_clk  = 1'b0;
    rst_b     = 1'b0;
    msgStart  = 1'b0;
    msgFields = '0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = 32'h0;
    errors    = 0;
    testsRun  = 0;
    gold = '{3'h0, 24'hfaa123, 23'h2aaaaa, 24'he00000, 1'b0, 12'h035, 4'h4, 2'h0, 11'h191,
             11'h065, 11'h402, 1'b1, 16'h0e1b, 16'h4d09, 16'h0cfc, 3'h0, 3'h1, 2'h0, 12'h4e2,
             4'h7, 3'h2, 1'b0, 2'h0, 3'h0, 1'b0, 12'h035};
    bits = {8{32'h3c5aa5c3}};
    pat = bits[$bits(lmrs_pkg::lmrs_fields_t)-1:0];
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(lmrs_pkg::CTRL_OFS, 32'h1, 1'b0, "ctrl reset");
    rd_chk(lmrs_pkg::COUNT_OFS, 32'h0, 1'b0, "count reset");
    start_msg(gold);
    watch_frame(GOLD, 2, gold);
    start_msg('1);
    watch_frame(ref_code('1), 1, pat);
    watch_frame(ref_code(pat), 0, pat);
    rd_chk(lmrs_pkg::COUNT_OFS, 32'h3, 1'b0, "count after three");
    rd_chk(12'h00c, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, lmrs_pkg::STATUS_OFS, 32'hffff_ffff, rd, err);
    rd_chk(lmrs_pkg::STATUS_OFS, 32'h0, 1'b0, "status after write");
    apb(1'b1, lmrs_pkg::CTRL_OFS, 32'h0, rd, err);
    rd_chk(lmrs_pkg::CTRL_OFS, 32'h0, 1'b0, "ctrl cleared");
    start_msg(gold);
    repeat (3) @(posedge core_clk);
    #1;
    chk("start while disabled", 2'b00, {busy, outValid});
    apb(1'b1, lmrs_pkg::CTRL_OFS, 32'h1, rd, err);
    start_msg(pat);
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("outputs in reset", 3'b000, {busy, outValid, outLast});
    @(posedge core_clk);
    rst_b <= 1'b1;
    start_msg(gold);
    watch_frame(GOLD, 0, gold);
    give_verdict();
  end
endmodule
`default_nettype wire
